//--- logic/tx_gearbox_regs.vh
// Constants for the transmit synchronous block gearbox.
// Assumes inclusion by the gearbox design file only; definitions only.
`ifndef TX_GEARBOX_REGS_VH
`define TX_GEARBOX_REGS_VH

// ****************************************************************
// Mode selector field positions
// ****************************************************************
`define MODE_ASYNC_BIT  4
`define MODE_CAUI_BIT   2
`define MODE_66B_BIT    0

// ****************************************************************
// Widths and lengths, in bits, and the 66B sequence mask
// ****************************************************************
`define ACC_W           192
`define CNT_W           8
`define HDR_LEN_66      8'h02
`define HDR_LEN_67      8'h03
`define WIDTH_16        8'h10
`define WIDTH_32        8'h20
`define WIDTH_64        8'h40
`define SEQ66_MASK      7'h3F

// ****************************************************************
// Fabric width codes
// ****************************************************************
`define DW_2BYTE        2'h0
`define DW_4BYTE        2'h1
`define DW_8BYTE        2'h2

// ****************************************************************
// Sequence pause locations
// ****************************************************************
`define PAUSE66_INT4    7'h20
`define PAUSE66_INT2    7'h1F
`define PAUSE67_INT4_A  7'h16
`define PAUSE67_MID     7'h2C
`define PAUSE67_INT4_C  7'h42
`define PAUSE67_INT2_A  7'h15
`define PAUSE67_INT2_C  7'h41

`endif

//--- logic/tx_sync_block_gearbox.v
// Transmit synchronous gearbox: header plus payload packing into a
// line word stream, with a word FIFO on the output side.
// Assumes user logic drives header, payload and sequence count on clk
// and obeys the pause locations; a single clock domain.
//
// Functional notes
// - One mode shared by transmit and receive.
// - Header bits [1:0]/[2:0]; CAUI B uses [5:3].
// - Sequence bits [5:0] or [6:0]; shared.
// - First word: header then 30 payload bits (66B, 32-bit lane).
// - Leftover bits first, then header, new payload.
// - Pause skips payload only; resume next cycle.
// - Accept 2, 4 or 8 byte fabric payload.
// - CAUI bit-interleaves two lane streams.
`timescale 1ns/100ps
`default_nettype none
`include "tx_gearbox_regs.vh"

// ****************************************************************
// Word FIFO with valid and ready on both sides
// ****************************************************************
module gb_word_fifo #(
	parameter WIDTH = 64,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] mem_q [0:DEPTH-1]; // Word storage.
	reg  [AW:0]      wr_q;              // Write pointer, wrap bit on top.
	reg  [AW:0]      rd_q;              // Read pointer, wrap bit on top.
	wire             full;              // Every slot holds a word.
	wire             empty;             // No word is waiting.
	wire             push;              // Word accepted this cycle.
	wire             pop;               // Word taken this cycle.
	integer          i;                 // Reset loop index.

	assign full      = (wr_q[AW] != rd_q[AW]) &&
	                   (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign push      = in_valid & ~full;
	assign pop       = out_ready & ~empty;
	// The head word comes straight from the storage flip-flops.
	assign out_data  = mem_q[rd_q[AW-1:0]];

	// Pointers and storage; a full FIFO refuses, so nothing is lost.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_q[i] <= {WIDTH{1'b0}};
			end
		end else begin
			if (push) begin
				mem_q[wr_q[AW-1:0]] <= in_data;
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule // gb_word_fifo

// ****************************************************************
// Gearbox top level
// ****************************************************************
module tx_sync_block_gearbox #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW    = 4
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        channel_tx_reset,
	input  wire        tx_gb_enable_cfg,
	input  wire [4:0]  gb_mode_cfg,
	input  wire        internal_width_cfg,
	input  wire [1:0]  data_width_cfg,
	input  wire [5:0]  block_header_in,
	input  wire [6:0]  seq_count_in,
	input  wire [63:0] payload_in,
	output wire        payload_ready,
	output wire        pause_active,
	output reg  [4:0]  rx_gb_mode,
	output wire [63:0] line_data,
	output wire        line_valid,
	input  wire        line_ready
);
	// Fabric width in bits from its code.
	function [7:0] fabric_bits;
		input [1:0] code;
		begin
			case (code)
				`DW_2BYTE: fabric_bits = `WIDTH_16;
				`DW_4BYTE: fabric_bits = `WIDTH_32;
				default:   fabric_bits = `WIDTH_64;
			endcase
		end
	endfunction

	// Low-bit mask of the given length.
	function [`ACC_W-1:0] low_mask;
		input [7:0] len;
		begin
			low_mask = ~({`ACC_W{1'b1}} << len);
		end
	endfunction

	// Pause test against the table for the active framing and path.
	function is_pause;
		input [6:0] seq;
		input       m66;
		input       int2;
		begin
			if (m66) begin
				is_pause = int2 ? (seq == `PAUSE66_INT2)
				                : (seq == `PAUSE66_INT4);
			end else if (int2) begin
				is_pause = (seq == `PAUSE67_INT2_A) ||
				           (seq == `PAUSE67_MID) ||
				           (seq == `PAUSE67_INT2_C);
			end else begin
				is_pause = (seq == `PAUSE67_INT4_A) ||
				           (seq == `PAUSE67_MID) ||
				           (seq == `PAUSE67_INT4_C);
			end
		end
	endfunction

	wire        gb_on;       // Synchronous gearbox selected.
	wire        caui;        // Two-lane interleaved operation.
	wire        mode66;      // 64B/66B framing, else 64B/67B.
	wire        int2;        // Lanes run as 2-byte gearboxes.
	wire [6:0]  seq_eff;     // Sequence count with unused bits dropped.
	wire        pause;       // Current count is a pause location.
	wire [7:0]  fab_w;       // Fabric payload width in bits.
	wire [7:0]  lane_w;      // Payload bits per lane per cycle.
	wire [7:0]  hdr_len;     // Header length of one block.
	reg  [1:0]  chunk_last;  // Last chunk index of a block.
	reg  [1:0]  chunk_q;     // Chunk index within current block.
	reg  [1:0]  chunk_d;     // Next chunk index.
	wire        fifo_ready;  // FIFO can take a word.
	wire        take;        // Payload accepted this cycle.
	wire        hdr_on;      // Header goes in ahead of this chunk.
	wire [63:0] lane_emit0;  // Word leaving lane A.
	wire [63:0] lane_emit1;  // Word leaving lane B.
	wire        emit0;       // Lane A holds a full word.
	reg  [63:0] merged;      // Interleaved or single lane word.
	reg  [63:0] fifo_in;     // Word offered to the FIFO.
	reg         fifo_push;   // Offer valid.
	integer     k;           // Interleave loop index.

	assign gb_on  = tx_gb_enable_cfg & ~gb_mode_cfg[`MODE_ASYNC_BIT];
	assign caui   = gb_mode_cfg[`MODE_CAUI_BIT];
	assign mode66 = gb_mode_cfg[`MODE_66B_BIT];
	// CAUI runs two 2-byte lane gearboxes.
	assign int2   = caui | ~internal_width_cfg;
	// Sequence bits in use per framing.
	assign seq_eff = mode66 ? (seq_count_in & `SEQ66_MASK)
	                        : seq_count_in;
	assign pause   = gb_on & is_pause(seq_eff, mode66, int2);
	assign pause_active = pause;
	assign fab_w   = fabric_bits(data_width_cfg);
	assign lane_w  = caui ? (fab_w >> 1) : fab_w;
	assign hdr_len = mode66 ? `HDR_LEN_66 : `HDR_LEN_67;
	// Pause blocks payload only; header waits for its chunk.
	assign take    = gb_on & ~pause & fifo_ready & ~channel_tx_reset;
	assign hdr_on  = (chunk_q == 2'h0);
	// Back-pressure from the FIFO also shows as payload not taken.
	assign payload_ready = gb_on ? take : (fifo_ready & ~channel_tx_reset);

	// Chunks per 64-bit block depend on the lane width.
	always @* begin
		case (lane_w)
			`WIDTH_16: chunk_last = 2'h3;
			`WIDTH_32: chunk_last = 2'h1;
			default:   chunk_last = 2'h0;
		endcase
	end

	// Chunk index advances only on accepted payload.
	always @* begin
		chunk_d = chunk_q;
		if (take) begin
			chunk_d = (chunk_q == chunk_last) ? 2'h0 : chunk_q + 2'h1;
		end
	end

	// Chunk index register; channel reset restarts block framing.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chunk_q <= 2'h0;
		end else if (channel_tx_reset) begin
			// Reset holds framing at block start.
			chunk_q <= 2'h0;
		end else begin
			chunk_q <= chunk_d;
		end
	end

	// Mode handed to the receive gearbox unchanged.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_gb_mode <= 5'h00;
		end else begin
			rx_gb_mode <= gb_mode_cfg;
		end
	end

	// ****************************************************************
	// Per-lane bit packers
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : lane
			reg  [`ACC_W-1:0] acc_q;  // Leftover bits, oldest at bit 0.
			reg  [`CNT_W-1:0] cnt_q;  // Number of leftover bits.
			wire [`ACC_W-1:0] pl;     // Payload slice of this lane.
			wire [`ACC_W-1:0] hdr;    // Header bits of this lane.
			wire [`ACC_W-1:0] ins;    // Bits appended this cycle.
			wire [`CNT_W-1:0] hl;     // Header bits appended.
			wire [`CNT_W-1:0] len;    // Total bits appended.
			wire [`ACC_W-1:0] tot;    // Leftover plus new bits.
			wire [`CNT_W-1:0] cnt_t;  // Bits in tot.
			wire              full_w; // A whole word is ready.
			wire              pop;    // Word leaves this cycle.

			// Lane B carries the upper payload half.
			assign pl  = (g == 0) ?
				({128'h0, payload_in} & low_mask(lane_w)) :
				(({128'h0, payload_in} >> lane_w) & low_mask(lane_w));
			// Header field per lane and framing.
			assign hdr = ((g == 0) ?
				{189'h0, block_header_in[2:0]} :
				{189'h0, block_header_in[5:3]}) & low_mask(hdr_len);
			assign hl  = hdr_on ? hdr_len : 8'h00;
			// Header sits below the payload it leads.
			assign ins = take ? ((pl << hl) | (hdr_on ? hdr : 192'h0))
			                  : {`ACC_W{1'b0}};
			assign len = take ? (lane_w + hl) : 8'h00;
			// New bits queue behind leftover bits.
			assign tot    = acc_q | (ins << cnt_q);
			assign cnt_t  = cnt_q + len;
			assign full_w = (cnt_t >= lane_w);
			assign pop    = gb_on & full_w & fifo_ready;

			// Packer state; pause cycles drain and add nothing.
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					acc_q <= {`ACC_W{1'b0}};
					cnt_q <= {`CNT_W{1'b0}};
				end else if (channel_tx_reset || !gb_on) begin
					acc_q <= {`ACC_W{1'b0}};
					cnt_q <= {`CNT_W{1'b0}};
				end else if (pop) begin
					acc_q <= tot >> lane_w;
					cnt_q <= cnt_t - lane_w;
				end else begin
					acc_q <= tot;
					cnt_q <= cnt_t;
				end
			end
		end
	endgenerate

	assign lane_emit0 = lane[0].tot[63:0] & ~({64{1'b1}} << lane_w);
	assign lane_emit1 = lane[1].tot[63:0] & ~({64{1'b1}} << lane_w);
	assign emit0      = lane[0].full_w;

	// Bit interleave of the two lanes in CAUI.
	always @* begin
		merged = lane_emit0;
		if (caui) begin
			for (k = 0; k < 32; k = k + 1) begin
				merged[2*k]   = lane_emit0[k];
				merged[2*k+1] = lane_emit1[k];
			end
		end
	end

	// Word offered to the FIFO; with the gearbox off payload passes raw.
	always @* begin
		if (gb_on) begin
			fifo_in   = merged;
			fifo_push = emit0 & ~channel_tx_reset;
		end else begin
			fifo_in   = payload_in & ~({64{1'b1}} << fab_w);
			fifo_push = ~channel_tx_reset;
		end
	end

	// Output buffer; a stalled line stalls the packers.
	gb_word_fifo #(
		.WIDTH (64),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (fifo_in),
		.in_valid  (fifo_push),
		.in_ready  (fifo_ready),
		.out_data  (line_data),
		.out_valid (line_valid),
		.out_ready (line_ready)
	);
endmodule // tx_sync_block_gearbox

`default_nettype wire

//--- tb/fabric_user_model.sv
// Fabric user logic: sequence count, headers and payload chunks.
// Assumes 66B framing, 32-bit fabric and 4-byte internal path.
`timescale 1ns/100ps
`default_nettype none
module fabric_user_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic        payload_ready,
	input  wire logic        pause_active,
	output logic      [6:0]  seq_q,
	output logic      [5:0]  hdr,
	output logic      [63:0] data
);
	logic        half_q; // Second fabric cycle of a count.
	logic [15:0] n_q;    // Chunks handed over so far.
	// stands in for scrambled data: bits flip each chunk.
	assign data = {2{n_q, ~n_q}};
	// header per block, spare bits held zero.
	assign hdr = {4'h0, n_q[1], ~n_q[1]};
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_q  <= 7'h00;
			half_q <= 1'h0;
			n_q    <= 16'h0000;
		end else if (!run) begin
			seq_q  <= 7'h00;
			half_q <= 1'h0;
		end else if (payload_ready | pause_active) begin
			half_q <= ~half_q;
			if (half_q) begin
				seq_q <= (seq_q == 7'h20) ? 7'h00 : seq_q + 7'h01;
			end
			if (payload_ready) begin
				n_q <= n_q + 16'h0001;
			end
		end
	end
endmodule // fabric_user_model
`default_nettype wire

//--- tb/gearbox_checker.sv
// Port-level checks for the transmit synchronous gearbox.
// Assumes one clock domain; bound to the gearbox top below.
`timescale 1ns/100ps
`default_nettype none
module gearbox_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        channel_tx_reset,
	input wire logic        tx_gb_enable_cfg,
	input wire logic [4:0]  gb_mode_cfg,
	input wire logic        internal_width_cfg,
	input wire logic [6:0]  seq_count_in,
	input wire logic        payload_ready,
	input wire logic        pause_active,
	input wire logic [4:0]  rx_gb_mode,
	input wire logic [63:0] line_data,
	input wire logic        line_valid,
	input wire logic        line_ready
);
	// ****************************************************************
	// Qualifiers
	// ****************************************************************
	// Pause rules only hold while the synchronous packer owns the data.
	wire on  = tx_gb_enable_cfg & ~gb_mode_cfg[4] & ~channel_tx_reset;
	wire n66 = on & gb_mode_cfg[0];
	wire n67 = on & ~gb_mode_cfg[0];
	// CAUI lanes run the narrow packers, so they share narrow pauses.
	wire w2  = ~internal_width_cfg | gb_mode_cfg[2];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// A word waiting at the head while the sink stalls.
	sequence s_stall;
		line_valid && !line_ready;
	endsequence
	a_pause_no_take: assert property (on && pause_active |-> !payload_ready)
		else $error("payload taken during pause");
	a_pause66_wide: assert property (n66 && !w2 && seq_count_in[5:0] == 6'h20 |-> pause_active)
		else $error("missing pause at 32");
	a_no_extra_pause: assert property (n66 && !w2 && seq_count_in[5:0] != 6'h20 |-> !pause_active)
		else $error("pause at wrong count");
	a_pause66_narrow: assert property (n66 && w2 && seq_count_in[5:0] == 6'h1F |-> pause_active)
		else $error("missing pause at 31");
	a_pause67_wide: assert property (n67 && !w2 && seq_count_in inside {7'h16, 7'h2C, 7'h42} |-> pause_active)
		else $error("missing wide pause");
	a_pause67_narrow: assert property (n67 && w2 && seq_count_in inside {7'h15, 7'h2C, 7'h41} |-> pause_active)
		else $error("missing narrow pause");
	a_mode_copy: assert property ($past(rst_n) |-> rx_gb_mode == $past(gb_mode_cfg))
		else $error("receive mode differs");
	a_line_hold: assert property (s_stall |=> line_valid && $stable(line_data))
		else $error("line word lost");
	a_reset_no_take: assert property (channel_tx_reset |-> !payload_ready)
		else $error("payload taken in reset");
endmodule // gearbox_checker
bind tx_sync_block_gearbox gearbox_checker u_chk (.clk, .rst_n,
	.channel_tx_reset, .tx_gb_enable_cfg, .gb_mode_cfg,
	.internal_width_cfg, .seq_count_in, .payload_ready, .pause_active,
	.rx_gb_mode, .line_data, .line_valid, .line_ready);
`default_nettype wire

//--- tb/tx_sync_block_gearbox_test.sv
// Self-checking bench for the transmit synchronous gearbox.
// Assumes the fabric model feeds the stream phase, the bench the rest.
`timescale 1ns/100ps
`default_nettype none
module tx_sync_block_gearbox_test;
	typedef struct packed {
		logic [4:0] m;
		logic       w;
		logic [6:0] s;
		logic       p;
	} row_t;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        channel_tx_reset = 1'h1;
	logic        tx_gb_enable_cfg = 1'h1;
	logic [4:0]  gb_mode_cfg = 5'h01;
	logic        internal_width_cfg = 1'h1;
	logic [1:0]  data_width_cfg = 2'h1;
	logic        line_ready = 1'h1;
	logic        track = 1'h0;  // Model owns the stream.
	logic [6:0]  tb_seq = 7'h00;
	logic        chunk = 1'h0;  // Expected chunk within a block.
	logic        q[$];          // Reference bit queue, first bit first.
	logic [31:0] exp_w;
	logic [6:0]  m_seq;
	logic [5:0]  block_header_in;
	logic [63:0] payload_in, line_data;
	logic [4:0]  rx_gb_mode;
	logic        payload_ready, pause_active, line_valid;
	int          error_cnt = 0, n_tests = 0, n_words = 0, cyc = 0;
	wire logic [6:0] seq_count_in = track ? m_seq : tb_seq;
	// legal modes, counts, CAUI width.
	// Mode, internal width, count, expected pause.
	row_t rows [13] = '{'{5'h01, 1'h1, 7'h20, 1'h1}, '{5'h01, 1'h1, 7'h1F, 1'h0},
		'{5'h01, 1'h0, 7'h1F, 1'h1}, '{5'h01, 1'h0, 7'h20, 1'h0},
		'{5'h00, 1'h1, 7'h16, 1'h1}, '{5'h00, 1'h1, 7'h2C, 1'h1},
		'{5'h00, 1'h1, 7'h42, 1'h1}, '{5'h00, 1'h1, 7'h15, 1'h0},
		'{5'h00, 1'h0, 7'h15, 1'h1}, '{5'h00, 1'h0, 7'h2C, 1'h1},
		'{5'h00, 1'h0, 7'h41, 1'h1}, '{5'h05, 1'h1, 7'h1F, 1'h1},
		'{5'h04, 1'h1, 7'h41, 1'h1}};
	// ****************************************************************
	// Instances
	// ****************************************************************
	fabric_user_model model (.clk, .rst_n, .run(track & ~channel_tx_reset),
		.payload_ready, .pause_active, .seq_q(m_seq),
		.hdr(block_header_in), .data(payload_in));
	tx_sync_block_gearbox dut (.clk, .rst_n, .channel_tx_reset,
		.tx_gb_enable_cfg, .gb_mode_cfg, .internal_width_cfg,
		.data_width_cfg, .block_header_in, .seq_count_in,
		.payload_in, .payload_ready, .pause_active, .rx_gb_mode,
		.line_data, .line_valid, .line_ready);
	// Clock at 20 MHz.
	initial forever #25 clk = ~clk;
	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// A hang counts as a mismatch; the run needs about 310 cycles.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			error_cnt++;
			print_verdict;
		end
	end
	// reference: header first, then payload from bit 0 up.
	always @(posedge clk) begin
		if (track && payload_ready === 1'h1) begin
			if (!chunk) begin
				q.push_back(block_header_in[0]);
				q.push_back(block_header_in[1]);
			end
			for (int i = 0; i < 32; i++) begin
				q.push_back(payload_in[i]);
			end
			chunk <= ~chunk;
		end
		if (track && line_valid === 1'h1 && line_ready === 1'h1) begin
			for (int i = 0; i < 32; i++) begin
				exp_w[i] = q.pop_front();
			end
			n_words++;
			chk_word("line word", exp_w, line_data[31:0]);
			chk_word("line upper", 32'h0, line_data[63:32]);
		end
	end
	// Reset, pause table, then a full, stalled and drained stream.
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk_bit("line valid in reset", 1'h0, line_valid);
		@(posedge clk) rst_n <= 1'h1;
		@(posedge clk) channel_tx_reset <= 1'h0;
		@(negedge clk);
		chk_word("receive mode", 32'h1, {27'h0, rx_gb_mode});
		foreach (rows[k]) begin
			@(posedge clk);
			gb_mode_cfg <= rows[k].m;
			internal_width_cfg <= rows[k].w;
			tb_seq <= rows[k].s;
			@(negedge clk);
			chk_bit("pause flag", rows[k].p, pause_active);
			chk_bit("payload ready", ~rows[k].p, payload_ready);
		end
		// Gearbox off: a 2-byte fabric word passes through raw.
		@(posedge clk);
		tx_gb_enable_cfg <= 1'h0;
		data_width_cfg <= 2'h0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk_word("raw word", {16'h0, payload_in[15:0]}, line_data[31:0]);
		chk_bit("raw ready", 1'h1, payload_ready);
		@(posedge clk);
		tx_gb_enable_cfg <= 1'h1;
		data_width_cfg <= 2'h1;
		gb_mode_cfg <= 5'h01;
		internal_width_cfg <= 1'h1;
		channel_tx_reset <= 1'h1;
		repeat (20) @(posedge clk);
		track <= 1'h1;
		channel_tx_reset <= 1'h0;
		line_ready <= 1'h0;
		repeat (40) @(posedge clk);
		@(negedge clk);
		chk_bit("ready when full", 1'h0, payload_ready);
		chk_bit("valid when full", 1'h1, line_valid);
		@(posedge clk) line_ready <= 1'h1;
		repeat (200) @(posedge clk);
		channel_tx_reset <= 1'h1;
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk_bit("drained", 1'h0, line_valid);
		chk_bit("words past pause", 1'h1, n_words > 100);
		print_verdict;
	end
endmodule // tx_sync_block_gearbox_test
`default_nettype wire
